//--- core/cmrt_top.v
// Multiple main-register transfer handler with AXI4-Lite register file
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "cmrt_map.vh"
module cmrt_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         cp_req,
  output reg         cp_we,
  output reg  [1:0]  cp_sel,
  output reg  [31:0] cp_wdata,
  input  wire [31:0] cp_rdata,
  input  wire        cp_ack,
  output reg         protocol_violation
);
  // ****************************************
  // States
  // ****************************************
  localparam S_IDLE = 2'h0;
  localparam S_PCW  = 2'h1;
  localparam S_MSK  = 2'h2;
  localparam S_XFER = 2'h3;

  // ****************************************
  // Helpers
  // ****************************************
  // Lowest pending register, data registers before address registers
  function [3:0] lowest;
    input [15:0] p;
    integer i;
    begin
      lowest = 4'h0;
      for (i = 15; i >= 0; i = i - 1) begin
        if (p[i]) begin
          lowest = i[3:0];
        end
      end
    end
  endfunction

  function [31:0] strobe;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer b;
    begin
      strobe = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (st[b]) begin
          strobe[b*8 +: 8] = nw[b*8 +: 8];
        end
      end
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  reg  [31:0] regs_r [0:15];
  reg  [1:0]  state_r;
  reg  [31:0] prim_r;
  reg  [31:0] iaddr_r;
  reg         cond_r;
  reg         dir_r;
  reg         done_r;
  reg  [15:0] mask_r;
  reg  [15:0] pend_a_r;
  reg  [15:0] pend_b_r;
  reg         aw_got_r;
  reg         w_got_r;
  reg  [7:0]  aw_addr_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;

  reg         fin_valid;
  reg  [31:0] fin_data;
  reg         fout_ready;
  wire        fin_ready;
  wire        fout_valid;
  wire [31:0] fout_data;

  wire        busy;
  wire        wr_go;
  wire        start;
  wire        prim_bad;
  wire [3:0]  a_idx;
  wire [3:0]  b_idx;
  wire        reg_hit_w;
  wire        reg_hit_r;

  assign busy      = (state_r != S_IDLE);
  assign wr_go     = aw_got_r && w_got_r && !s_axi_bvalid;
  assign start     = wr_go && (aw_addr_r == `CMRT_OFS_CTRL) && w_strb_r[0]
                     && w_data_r[`CMRT_CTRL_START] && !busy;
  assign prim_bad  = (prim_r[`CMRT_PAT_MSB:0] != `CMRT_PAT); // RL1
  assign a_idx     = lowest(pend_a_r); // RL6
  assign b_idx     = lowest(pend_b_r); // RL9
  assign reg_hit_w = (aw_addr_r[7:6] == 2'h1);
  assign reg_hit_r = (s_axi_araddr[7:6] == 2'h1);

  // ****************************************
  // Operand FIFO
  // ****************************************
  cmrt_fifo #(
    .WIDTH (32),
    .DEPTH (`CMRT_FIFO_DEPTH),
    .AW    (2)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (fin_valid),
    .in_ready  (fin_ready),
    .in_data   (fin_data),
    .out_valid (fout_valid),
    .out_ready (fout_ready),
    .out_data  (fout_data)
  );

  // Outgoing: registers fill the FIFO, the port drains it one write at a time.
  // Incoming: a read is issued only with FIFO room, so the answer always fits.
  always @* begin
    fin_valid  = 1'b0;
    fin_data   = 32'h0000_0000;
    fout_ready = 1'b0;
    if (state_r == S_XFER) begin
      if (!dir_r) begin
        fin_valid  = |pend_a_r;
        fin_data   = regs_r[a_idx]; // RL7
        fout_ready = !cp_req;
      end else begin
        fin_valid  = cp_req && cp_ack; // RL8
        fin_data   = cp_rdata;
        fout_ready = 1'b1;
      end
    end
  end

  // ****************************************
  // Write channels
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= `CMRT_RST_WORD;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r      <= 1'b1;
        aw_addr_r     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r      <= 1'b1;
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (reg_hit_w || aw_addr_r == `CMRT_OFS_CTRL || aw_addr_r == `CMRT_OFS_PRIM
            || aw_addr_r == `CMRT_OFS_STAT || aw_addr_r == `CMRT_OFS_MASK
            || aw_addr_r == `CMRT_OFS_IADDR) begin
          s_axi_bresp <= 2'h0;
        end else begin
          s_axi_bresp <= 2'h2;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `CMRT_RST_WORD;
      s_axi_rresp   <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= 2'h0;
      s_axi_rdata   <= 32'h0000_0000;
      if (reg_hit_r) begin
        s_axi_rdata <= regs_r[s_axi_araddr[5:2]];
      end else begin
        case (s_axi_araddr)
          `CMRT_OFS_CTRL: begin
            s_axi_rdata <= {30'h0000_0000, cond_r, 1'b0};
          end
          `CMRT_OFS_PRIM: begin
            s_axi_rdata <= prim_r;
          end
          `CMRT_OFS_STAT: begin
            s_axi_rdata <= {28'h000_0000, dir_r, protocol_violation, done_r, busy};
          end
          `CMRT_OFS_MASK: begin
            s_axi_rdata <= {16'h0000, mask_r};
          end
          `CMRT_OFS_IADDR: begin
            s_axi_rdata <= iaddr_r;
          end
          default: begin
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // Transfer engine and registers
  // ****************************************
  integer k;
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_r            <= S_IDLE;
      prim_r             <= `CMRT_RST_PRIM;
      iaddr_r            <= `CMRT_RST_WORD;
      cond_r             <= 1'b0;
      dir_r              <= 1'b0;
      done_r             <= 1'b0;
      protocol_violation <= 1'b0;
      mask_r             <= 16'h0000;
      pend_a_r           <= 16'h0000;
      pend_b_r           <= 16'h0000;
      cp_req             <= 1'b0;
      cp_we              <= 1'b0;
      cp_sel             <= `CMRT_SEL_OPER;
      cp_wdata           <= `CMRT_RST_WORD;
      for (k = 0; k < 16; k = k + 1) begin
        regs_r[k] <= `CMRT_RST_WORD;
      end
    end else begin
      // Software writes; the register file and primitive are locked while busy
      if (wr_go) begin
        if (reg_hit_w && !busy) begin
          regs_r[aw_addr_r[5:2]] <= strobe(regs_r[aw_addr_r[5:2]], w_data_r, w_strb_r);
        end
        if (aw_addr_r == `CMRT_OFS_PRIM && !busy) begin
          prim_r <= strobe(prim_r, w_data_r, w_strb_r);
        end
        if (aw_addr_r == `CMRT_OFS_IADDR && !busy) begin
          iaddr_r <= strobe(iaddr_r, w_data_r, w_strb_r);
        end
        if (aw_addr_r == `CMRT_OFS_CTRL && w_strb_r[0] && !busy) begin
          cond_r <= w_data_r[`CMRT_CTRL_COND]; // RL2
        end
        // Write one to clear; a set in the same cycle below wins
        if (aw_addr_r == `CMRT_OFS_STAT && w_strb_r[0]) begin
          if (w_data_r[`CMRT_ST_DONE]) begin
            done_r <= 1'b0;
          end
          if (w_data_r[`CMRT_ST_VIOL]) begin
            protocol_violation <= 1'b0;
          end
        end
      end
      case (state_r)
        S_IDLE: begin
          if (start) begin
            dir_r <= prim_r[`CMRT_DIR_BIT];
            if (prim_bad || (w_data_r[`CMRT_CTRL_COND] && !prim_r[`CMRT_AGAIN_BIT])) begin
              protocol_violation <= 1'b1; // RL3
            end else if (prim_r[`CMRT_PASS_BIT]) begin
              cp_req   <= 1'b1; // RL11
              cp_we    <= 1'b1;
              cp_sel   <= `CMRT_SEL_IADDR;
              cp_wdata <= iaddr_r;
              state_r  <= S_PCW;
            end else begin
              state_r <= S_MSK; // RL4
            end
          end
        end
        S_PCW: begin
          if (cp_ack) begin
            cp_req  <= 1'b0; // RL11
            state_r <= S_MSK;
          end
        end
        S_MSK: begin
          if (!cp_req) begin
            cp_req <= 1'b1; // RL4
            cp_we  <= 1'b0;
            cp_sel <= `CMRT_SEL_RSEL;
          end else if (cp_ack) begin
            mask_r   <= cp_rdata[15:0];
            pend_a_r <= cp_rdata[15:0]; // RL5
            pend_b_r <= cp_rdata[15:0];
            cp_req   <= 1'b0;
            cp_sel   <= `CMRT_SEL_OPER;
            if (cp_rdata[15:0] == 16'h0000) begin
              done_r  <= 1'b1; // RL10
              state_r <= S_IDLE;
            end else begin
              state_r <= S_XFER;
            end
          end
        end
        S_XFER: begin
          if (!dir_r) begin
            if (fin_valid && fin_ready) begin
              pend_a_r[a_idx] <= 1'b0; // RL6
            end
            if (!cp_req && fout_valid) begin
              cp_req   <= 1'b1; // RL7
              cp_we    <= 1'b1;
              cp_wdata <= fout_data;
            end
            if (cp_req && cp_ack) begin
              cp_req          <= 1'b0;
              pend_b_r[b_idx] <= 1'b0;
              if (pend_b_r == (16'h0001 << b_idx)) begin
                done_r  <= 1'b1;
                state_r <= S_IDLE;
              end
            end
          end else begin
            if (!cp_req && (|pend_a_r) && fin_ready) begin
              cp_req <= 1'b1; // RL8
              cp_we  <= 1'b0;
            end
            if (cp_req && cp_ack) begin
              cp_req          <= 1'b0;
              pend_a_r[a_idx] <= 1'b0;
            end
            if (fout_valid) begin
              regs_r[b_idx]   <= fout_data; // RL9
              pend_b_r[b_idx] <= 1'b0;
              if (pend_b_r == (16'h0001 << b_idx)) begin
                done_r  <= 1'b1;
                state_r <= S_IDLE;
              end
            end
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule // cmrt_top

//--- shared/cmrt_map.vh
// Constants of the multiple register transfer handler
// Function
// RL1 - Primitive word holds come-again in bit 15, pass-address in 14, direction in 13, pattern 0x0600 below.
// RL2 - The primitive is accepted for both the general and the conditional category.
// RL3 - Come-again clear under the conditional category raises a protocol violation, no transfer.
// RL4 - The 16-bit register-select mask is read from the coprocessor before any operand moves.
// RL5 - Mask bits 0-7 select data registers, bits 8-15 address registers; only set bits take part.
// RL6 - Selected registers move in ascending order, data registers first, unselected ones skipped.
// RL7 - With direction zero each selected register is written to the operand port as one long word.
// RL8 - With direction one one long word is read from the operand port into each selected register.
// RL9 - The register order is the same for both directions.
// RL10 - An all-zero mask moves no operand and ends the primitive at once.
// RL11 - With pass-address set the instruction address is written before the mask is read.
`ifndef CMRT_MAP_VH
`define CMRT_MAP_VH
// ****************************************
// Primitive word fields
// ****************************************
`define CMRT_AGAIN_BIT   15
`define CMRT_PASS_BIT    14
`define CMRT_DIR_BIT     13
`define CMRT_PAT_MSB     12
`define CMRT_PAT         13'h0600
// ****************************************
// Coprocessor interface register selects
// ****************************************
`define CMRT_SEL_OPER    2'h0
`define CMRT_SEL_RSEL    2'h1
`define CMRT_SEL_IADDR   2'h2
// ****************************************
// Register map, byte offsets
// ****************************************
`define CMRT_OFS_CTRL    8'h00
`define CMRT_OFS_PRIM    8'h04
`define CMRT_OFS_STAT    8'h08
`define CMRT_OFS_MASK    8'h0c
`define CMRT_OFS_IADDR   8'h10
`define CMRT_OFS_REGS    8'h40
// ****************************************
// Field positions and reset values
// ****************************************
`define CMRT_CTRL_START  0
`define CMRT_CTRL_COND   1
`define CMRT_ST_BUSY     0
`define CMRT_ST_DONE     1
`define CMRT_ST_VIOL     2
`define CMRT_ST_DIR      3
`define CMRT_RST_WORD    32'h0000_0000
`define CMRT_RST_PRIM    32'h0000_0600
`define CMRT_FIFO_DEPTH  4
`endif

//--- core/cmrt_fifo.v
// Small synchronous FIFO for the operand path
`timescale 1ns/100ps
module cmrt_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wp_r;
  reg [AW-1:0]    rp_r;
  reg [AW:0]      cnt_r;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Depth must be a power of two; pointers wrap naturally
  always @(posedge aclk) begin
    if (!aresetn) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_data;
        wp_r        <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // cmrt_fifo

//--- sim/cmrt_top_sva.sv
// Concurrent checks on the transfer handler ports
`timescale 1ns/100ps
`include "cmrt_map.vh"
module cmrt_top_sva (
  input wire        aclk,
  input wire        aresetn,
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        cp_req,
  input wire        cp_we,
  input wire [1:0]  cp_sel,
  input wire [31:0] cp_wdata,
  input wire        cp_ack,
  input wire        protocol_violation
);
  // ****
  // Mask read tracker
  // ****
  // A control write is the only way to start, so it rearms the tracker
  reg mask_seen_r;
  always @(posedge aclk) begin
    if (!aresetn || (s_axi_awvalid && s_axi_awready && s_axi_awaddr == `CMRT_OFS_CTRL))
      mask_seen_r <= 1'b0;
    else if (cp_req && cp_ack && cp_sel == `CMRT_SEL_RSEL)
      mask_seen_r <= 1'b1;
  end
  default clocking dcb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_REQ_HOLD: assert property (cp_req && !cp_ack |=> cp_req && $stable({cp_we, cp_sel, cp_wdata}))
    else $error("coprocessor request changed before ack");
  AST_REQ_DROP: assert property (cp_req && cp_ack |=> !cp_req)
    else $error("coprocessor request held after ack");
  AST_RSEL_READ: assert property (cp_req && cp_sel == `CMRT_SEL_RSEL |-> !cp_we)
    else $error("mask access is not a read");
  AST_IADDR_WRITE: assert property (cp_req && cp_sel == `CMRT_SEL_IADDR |-> cp_we)
    else $error("instruction address access is not a write");
  AST_OPER_AFTER_MASK: assert property (cp_req && cp_sel == `CMRT_SEL_OPER |-> mask_seen_r)
    else $error("operand moved before mask read");
  AST_VIOL_QUIET: assert property ($rose(protocol_violation) |-> !cp_req [*4])
    else $error("access made after protocol violation");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel open while response pending");
  cover property (cp_req && cp_ack && cp_sel == `CMRT_SEL_IADDR);
  cover property (cp_req && cp_ack && !cp_we && cp_sel == `CMRT_SEL_OPER);
  cover property ($rose(protocol_violation));
endmodule // cmrt_top_sva
bind cmrt_top cmrt_top_sva cmrt_top_sva_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .cp_req, .cp_we, .cp_sel, .cp_wdata, .cp_ack, .protocol_violation);

//--- sim/cmrt_cop_model.sv
// Behavioural coprocessor answering interface register accesses
`timescale 1ns/100ps
`include "cmrt_map.vh"
module cmrt_cop_model (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        cp_req,
  input  wire        cp_we,
  input  wire [1:0]  cp_sel,
  input  wire [31:0] cp_wdata,
  input  wire [15:0] mask,
  input  wire [3:0]  delay,
  output reg  [31:0] cp_rdata,
  output reg         cp_ack
);
  // Entries are {select, write, data} in completion order
  logic [34:0] log_q [$];
  logic [31:0] val;
  reg   [3:0]  wait_r;
  reg          served_r;
  always @(posedge aclk) begin
    cp_ack   <= 1'b0;
    // Data is valid in the ack cycle only; toggling keeps stale values from passing
    cp_rdata <= ~cp_rdata;
    if (!aresetn) begin
      wait_r   <= 4'h0;
      served_r <= 1'b0;
      cp_rdata <= 32'h0;
    end else if (!cp_req) begin
      served_r <= 1'b0;
    end else if (!served_r) begin
      if (wait_r != delay) begin
        wait_r <= wait_r + 4'h1;
      end else begin
        val = (cp_sel == `CMRT_SEL_RSEL) ? {16'h0, mask} : 32'h5a00_0000 + 32'(log_q.size());
        wait_r   <= 4'h0;
        served_r <= 1'b1;
        cp_ack   <= 1'b1;
        cp_rdata <= val;
        log_q.push_back({cp_sel, cp_we, cp_we ? cp_wdata : val});
      end
    end
  end
endmodule // cmrt_cop_model

//--- sim/tb_coproc_multi_reg_transfer.sv
// Self-checking bench for the multiple register transfer handler
`timescale 1ns/100ps
`include "cmrt_map.vh"
module tb_coproc_multi_reg_transfer;
  logic        aclk = 1'b0;
  logic        aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb, cop_dly;
  logic [15:0] cop_mask;
  logic [1:0]  wr_resp;
  logic [31:0] regv [16];
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         cp_req, cp_we, cp_ack, protocol_violation;
  wire  [1:0]  s_axi_bresp, s_axi_rresp, cp_sel;
  wire  [31:0] s_axi_rdata, cp_wdata, cp_rdata;
  int          fail_count, samples_checked;
  cmrt_top cmrt_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cp_req, .cp_we, .cp_sel, .cp_wdata, .cp_rdata, .cp_ack,
    .protocol_violation);
  cmrt_cop_model cmrt_cop_model_inst (.aclk, .aresetn, .cp_req, .cp_we, .cp_sel, .cp_wdata,
    .mask(cop_mask), .delay(cop_dly), .cp_rdata, .cp_ack);
  always #12.5 aclk = ~aclk;
  // ****
  // Bus tasks
  // ****
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    wr_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [34:0] s, input logic [34:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk($sformatf("resp %h", a), {33'b0, r}, {33'b0, re});
    if (re == 2'b00) chk($sformatf("data %h", a), {3'b0, d}, {3'b0, e});
  endtask
  // One primitive from start to completion, with the access log compared afterwards
  task automatic run(input logic [15:0] p, input logic c, input logic [15:0] m,
                     input logic [3:0] dl, input logic v);
    logic [31:0] d;
    logic [1:0]  r;
    logic [34:0] e [$];
    cop_mask <= m;
    cop_dly  <= dl;
    cmrt_cop_model_inst.log_q.delete();
    axi_wr(`CMRT_OFS_STAT, 32'h6);
    chk("violation clear", {34'b0, protocol_violation}, 35'h0);
    axi_wr(`CMRT_OFS_IADDR, {p, ~p});
    axi_wr(`CMRT_OFS_PRIM, {16'h0, p});
    axi_wr(`CMRT_OFS_CTRL, {30'h0, c, 1'b1});
    do axi_rd(`CMRT_OFS_STAT, d, r); while (d[2:1] == 2'b00);
    chk("status", {33'b0, d[2:1]}, v ? 35'h2 : 35'h1);
    chk("violation pin", {34'b0, protocol_violation}, {34'b0, v});
    rchk(`CMRT_OFS_CTRL, {30'h0, c, 1'b0}, 2'b00);
    if (!v) begin
      chk("direction", {34'b0, d[3]}, {34'b0, p[13]});
      if (p[14]) e.push_back({`CMRT_SEL_IADDR, 1'b1, p, ~p});
      e.push_back({`CMRT_SEL_RSEL, 1'b0, 16'h0, m});
      for (int i = 0; i < 16; i++) begin
        if (m[i] && p[13]) regv[i] = 32'h5a00_0000 + 32'(e.size());
        if (m[i]) e.push_back({`CMRT_SEL_OPER, ~p[13], regv[i]});
      end
      rchk(`CMRT_OFS_MASK, {16'h0, m}, 2'b00);
    end
    chk("access count", 35'(cmrt_cop_model_inst.log_q.size()), 35'(e.size()));
    foreach (e[k]) chk("access", cmrt_cop_model_inst.log_q[k], e[k]);
    for (int i = 0; i < 16; i++) rchk(`CMRT_OFS_REGS + 8'(4 * i), regv[i], 2'b00);
  endtask
  task automatic final_report;
    if (fail_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, aresetn} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cop_mask, cop_dly} = '0;
    s_axi_wstrb = 4'hf;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`CMRT_OFS_CTRL, `CMRT_RST_WORD, 2'b00);
    rchk(`CMRT_OFS_PRIM, `CMRT_RST_PRIM, 2'b00);
    rchk(`CMRT_OFS_STAT, `CMRT_RST_WORD, 2'b00);
    rchk(8'h20, 32'h0, 2'b10);
    axi_wr(8'h24, 32'h1);
    chk("unmapped write", {33'b0, wr_resp}, 35'h2);
    // Mask register is read-only
    axi_wr(`CMRT_OFS_MASK, 32'hffff);
    rchk(`CMRT_OFS_MASK, `CMRT_RST_WORD, 2'b00);
    for (int i = 0; i < 16; i++) begin
      regv[i] = 32'h7700_0000 + 32'(i);
      axi_wr(`CMRT_OFS_REGS + 8'(4 * i), regv[i]);
    end
    run(16'h8600, 1'b0, 16'h8181, 4'h0, 1'b0);
    run(16'he600, 1'b0, 16'hffff, 4'h3, 1'b0);
    run(16'h0600, 1'b0, 16'h0000, 4'h1, 1'b0);
    run(16'h0600, 1'b1, 16'h0001, 4'h0, 1'b1);
    run(16'h8601, 1'b0, 16'h0001, 4'h0, 1'b1);
    run(16'h8600, 1'b1, 16'h0101, 4'h2, 1'b0);
    run(16'h2600, 1'b0, 16'h0180, 4'h0, 1'b0);
    final_report();
  end
  // Whole run needs under a thousand cycles
  initial begin
    repeat (30000) @(posedge aclk);
    fail_count++;
    final_report();
  end
endmodule // tb_coproc_multi_reg_transfer
